// File: src/lsd_driver.sv
// Segment display driver: registers, display memory, timebase and pin waveforms
//
// Implementation choices: register access over APB and the register offsets.
`include "lsd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lsd_driver
	import lsd_pkg::*;
#(
	parameter logic [15:0] SLOW_OSC_CYCLES = 16'(`LSD_SLOW_OSC_CYCLES)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sys_reset_req,
	input wire logic wdt_lowpower_reset,
	output logic [3:0][1:0] com_pin_level,
	output logic [3:0] com_pin_oe,
	output logic [22:0][1:0] seg_pin_level,
	output logic [22:0] seg_pin_oe,
	output logic bias_source_select,
	output logic pump_clk_en
);
	localparam logic [11:0] HOLD_LAST = 12'(`LSD_HOLD_CYCLES - 1);

	logic [7:0] ctrl_q, ctrl_d;
	logic [3:0] share_q, share_d;
	logic [3:0] mem_q [`LSD_MEM_WORDS];
	logic [3:0] mem_d [`LSD_MEM_WORDS];
	lsd_state_type state_q, state_d;
	logic [11:0] hold_q, hold_d;
	logic [1:0] slot_q, slot_d;
	logic pol_q, pol_d;
	logic [31:0] prdata_q, prdata_d;
	logic pump_q, pump_d;
	logic [3:0][1:0] com_lvl_q, com_lvl_d;
	logic [3:0] com_oe_q, com_oe_d;
	logic [22:0][1:0] seg_lvl_q, seg_lvl_d;
	logic [22:0] seg_oe_q, seg_oe_d;
	logic disp_rst, slow_tick, lcd_tick, pump_tick;
	logic en, type_b, duty4, last_slot, adv, pump_restart;
	logic [3:0] share_eff;
	logic [24:0][1:0] seg_sig;
	logic [3:0][1:0] com_sig;
	logic setup_ph, access_ph, wr, rd_ok;
	logic [4:0] mem_idx;

	// Pump divide ratio of the 3-bit field
	function automatic logic [15:0] pump_ratio(input logic [2:0] f);
		case (f)
			3'h0: pump_ratio = 16'h0080;
			3'h1: pump_ratio = 16'h0040;
			3'h2: pump_ratio = 16'h0020;
			3'h3: pump_ratio = 16'h0010;
			3'h4: pump_ratio = 16'h0008;
			3'h5: pump_ratio = 16'h0004;
			default: pump_ratio = 16'h0002;
		endcase
	endfunction

	// Extreme level for a polarity
	function automatic logic [1:0] extreme(input logic p);
		extreme = p ? LV_HIGH : LV_LOW;
	endfunction

	// Memory word index of an in-range address
	function automatic logic [4:0] word_index(input logic [11:0] a);
		logic [11:0] off;
		off = a - `LSD_ADDR_MEM_BASE;
		word_index = off[6:2];
	endfunction

	// Control decode
	assign en = ctrl_q[`LSD_CTRL_EN];
	assign type_b = ctrl_q[`LSD_CTRL_TYPE];
	assign duty4 = ctrl_q[`LSD_CTRL_DUTY];
	assign disp_rst = sys_reset_req && !wdt_lowpower_reset;
	assign last_slot = slot_q == (duty4 ? 2'h3 : 2'h2);
	assign adv = lcd_tick && (type_b || pol_q);
	// Restart the pump count when the divider field changes, so no short first gap
	assign pump_restart = state_q != ST_RUN
		|| ctrl_d[`LSD_CTRL_PUMP_HI:`LSD_CTRL_PUMP_LO] != ctrl_q[`LSD_CTRL_PUMP_HI:`LSD_CTRL_PUMP_LO];

	// Timebase: slow oscillator, display clock, pump clock
	lsd_tick_div u_slow (
		.pclk(pclk),
		.presetn(presetn),
		.clear(1'b0),
		.step_en(1'b1),
		.ratio(SLOW_OSC_CYCLES),
		.tick(slow_tick)
	);

	lsd_tick_div u_lcd (
		.pclk(pclk),
		.presetn(presetn),
		.clear(state_q != ST_RUN),
		.step_en(slow_tick),
		.ratio(`LSD_DISPLAY_DIV),
		.tick(lcd_tick)
	);

	lsd_tick_div u_pump (
		.pclk(pclk),
		.presetn(presetn),
		.clear(pump_restart),
		.step_en(slow_tick),
		.ratio(pump_ratio(ctrl_q[`LSD_CTRL_PUMP_HI:`LSD_CTRL_PUMP_LO])),
		.tick(pump_tick)
	);

	// APB phases and decode
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign wr = access_ph && pwrite;
	assign mem_idx = word_index(paddr);
	assign pready = access_ph;
	assign prdata = prdata_q;

	always_comb begin
		rd_ok = 1'b0;
		if (paddr == `LSD_ADDR_CTRL || paddr == `LSD_ADDR_SHARE) begin
			rd_ok = 1'b1;
		end else if (paddr == `LSD_ADDR_STATUS) begin
			rd_ok = 1'b1;
		end else if (paddr >= `LSD_ADDR_MEM_BASE && paddr <= `LSD_ADDR_MEM_LAST) begin
			rd_ok = paddr[1:0] == 2'h0;
		end
		pslverr = access_ph && !rd_ok;
	end

	// Register, memory and read-data next values
	always_comb begin
		ctrl_d = ctrl_q;
		share_d = share_q;
		mem_d = mem_q;
		prdata_d = prdata_q;
		if (wr && rd_ok) begin
			if (paddr == `LSD_ADDR_CTRL) begin
				ctrl_d = pwdata[7:0] & `LSD_CTRL_MASK;
			end else if (paddr == `LSD_ADDR_SHARE) begin
				share_d = pwdata[3:0];
			end else if (paddr != `LSD_ADDR_STATUS) begin
				mem_d[mem_idx] = pwdata[3:0];
			end
		end
		if (setup_ph && !pwrite) begin
			if (paddr == `LSD_ADDR_CTRL) begin
				prdata_d = {24'h000000, ctrl_q};
			end else if (paddr == `LSD_ADDR_SHARE) begin
				// Common-to-segment bits read zero at quarter duty
				prdata_d = {28'h0000000, share_q[3:2], duty4 ? 2'h0 : share_q[1:0]};
			end else if (paddr == `LSD_ADDR_STATUS) begin
				prdata_d = {27'h0000000, pol_q, slot_q, state_q};
			end else if (paddr >= `LSD_ADDR_MEM_BASE && paddr <= `LSD_ADDR_MEM_LAST) begin
				prdata_d = {28'h0000000, mem_q[mem_idx]};
			end else begin
				prdata_d = 32'h00000000;
			end
		end
		if (disp_rst) begin
			ctrl_d = `LSD_CTRL_RESET;
			share_d = `LSD_SHARE_RESET;
		end
	end

	// State, reset hold and frame sequencer
	always_comb begin
		state_d = state_q;
		hold_d = hold_q;
		slot_d = slot_q;
		pol_d = pol_q;
		case (state_q)
			ST_FLOAT: begin
				// Float for reset delay plus start-up after release
				if (hold_q == HOLD_LAST) begin
					state_d = ST_OFF;
				end else begin
					hold_d = hold_q + 12'h001;
				end
			end
			ST_OFF: begin
				if (en) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!en) begin
					state_d = ST_OFF;
				end else if (lcd_tick) begin
					// Type A flips every tick, type B at frame wrap
					if (!type_b) begin
						pol_d = !pol_q;
					end else if (last_slot) begin
						pol_d = !pol_q;
					end
					if (adv) begin
						slot_d = last_slot ? 2'h0 : slot_q + 2'h1;
					end
				end
			end
			default: state_d = ST_FLOAT;
		endcase
		// Drop a slot past the active commons when duty falls to a third
		if (!ctrl_d[`LSD_CTRL_DUTY] && slot_d == 2'h3) begin
			slot_d = 2'h0;
		end
		if (state_d != ST_RUN) begin
			slot_d = 2'h0;
			pol_d = 1'b0;
		end
		if (disp_rst) begin
			state_d = ST_FLOAT;
			hold_d = 12'h000;
		end
	end

	// Common and segment signal levels for the current slot
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			com_sig[c] = (2'(c) == slot_q) ? extreme(pol_q) : LV_MID;
		end
		for (int s = 0; s < `LSD_MEM_WORDS; s++) begin
			// Lit pixel opposes the common, dark pixel follows it
			seg_sig[s] = extreme(pol_q ^ mem_q[s][slot_q]);
		end
	end

	// Pin sharing, with common pin 3 forced to segment 23 at third duty
	assign share_eff = {share_q[3:2], share_q[1] | !duty4, share_q[0]};

	// Pin level and drive next values
	always_comb begin
		com_lvl_d = '0;
		seg_lvl_d = '0;
		com_oe_d = 4'hF;
		seg_oe_d = '1;
		pump_d = 1'b0;
		if (state_q == ST_FLOAT) begin
			com_oe_d = 4'h0;
			seg_oe_d = '0;
		end else if (state_q == ST_RUN) begin
			com_lvl_d[0] = com_sig[0];
			com_lvl_d[1] = com_sig[1];
			com_lvl_d[2] = share_eff[`LSD_SHARE_COMMON_LINE_2_SEG] ? seg_sig[24] : com_sig[2];
			com_lvl_d[3] = share_eff[`LSD_SHARE_COMMON_LINE_3_SEG] ? seg_sig[23] : com_sig[3];
			for (int s = 2; s < 23; s++) begin
				seg_lvl_d[s] = seg_sig[s];
			end
			seg_lvl_d[0] = share_eff[`LSD_SHARE_PIN0_COM] ? com_sig[2] : seg_sig[0];
			seg_lvl_d[1] = share_eff[`LSD_SHARE_PIN1_COM] ? com_sig[3] : seg_sig[1];
			pump_d = pump_tick;
		end
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `LSD_CTRL_RESET;
			share_q <= `LSD_SHARE_RESET;
			for (int i = 0; i < `LSD_MEM_WORDS; i++) begin
				mem_q[i] <= 4'h0;
			end
			state_q <= ST_FLOAT;
			hold_q <= 12'h000;
			slot_q <= 2'h0;
			pol_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pump_q <= 1'b0;
			com_lvl_q <= '0;
			seg_lvl_q <= '0;
			com_oe_q <= 4'h0;
			seg_oe_q <= '0;
		end else begin
			ctrl_q <= ctrl_d;
			share_q <= share_d;
			mem_q <= mem_d;
			state_q <= state_d;
			hold_q <= hold_d;
			slot_q <= slot_d;
			pol_q <= pol_d;
			prdata_q <= prdata_d;
			pump_q <= pump_d;
			com_lvl_q <= com_lvl_d;
			seg_lvl_q <= seg_lvl_d;
			com_oe_q <= com_oe_d;
			seg_oe_q <= seg_oe_d;
		end
	end

	// Outputs
	assign com_pin_level = com_lvl_q;
	assign com_pin_oe = com_oe_q;
	assign seg_pin_level = seg_lvl_q;
	assign seg_pin_oe = seg_oe_q;
	assign bias_source_select = ctrl_q[`LSD_CTRL_BIAS];
	assign pump_clk_en = pump_q;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [4:0] slow_seen_q;
	logic [8:0] pump_gap_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_seen_q <= 5'h00;
			pump_gap_q <= 9'h000;
		end else begin
			slow_seen_q <= lcd_tick ? 5'h00 : (state_q != ST_RUN ? 5'h00 :
				slow_seen_q + 5'(slow_tick));
			pump_gap_q <= pump_tick ? 9'h000 : (pump_restart ? 9'h000 :
				pump_gap_q + 9'(slow_tick));
		end
	end

	sequence disable_seen_s;
		state_q == ST_RUN && !en;
	endsequence
	sequence pins_low_s;
		com_pin_oe == 4'hF && seg_pin_oe == '1 && com_pin_level == '0 && seg_pin_level == '0;
	endsequence

	disable_low_a: assert property (disable_seen_s |=> ##1 pins_low_s)
		else $error("pins not driven low after disable");
	reset_float_a: assert property (disp_rst |=> ##1 (com_pin_oe == 4'h0 && seg_pin_oe == '0))
		else $error("pins not floated during system reset");
	hold_length_a: assert property ($past(state_q) == ST_FLOAT && state_q == ST_OFF
		|-> $past(hold_q) == HOLD_LAST)
		else $error("float hold length wrong");
	wdt_keep_a: assert property (sys_reset_req && wdt_lowpower_reset && state_q == ST_RUN
		|=> state_q != ST_FLOAT)
		else $error("low-power watchdog reset floated outputs");
	slot_range_a: assert property (state_q == ST_RUN |-> (duty4 ? 1'b1 : slot_q != 2'h3))
		else $error("slot beyond active commons");
	lcd_div_a: assert property (lcd_tick |-> slow_tick && slow_seen_q == 5'h07)
		else $error("display tick not slow clock over eight");
	pump_div_a: assert property (pump_tick |-> pump_gap_q
		== 9'(pump_ratio(ctrl_q[`LSD_CTRL_PUMP_HI:`LSD_CTRL_PUMP_LO]) - 16'h0001))
		else $error("pump tick spacing wrong");
	type_b_pol_a: assert property (state_q == ST_RUN && type_b && $changed(pol_q)
		&& $past(state_q) == ST_RUN && $past(type_b) |-> slot_q == 2'h0)
		else $error("type B polarity changed mid frame");
	type_a_pol_a: assert property (state_q == ST_RUN && en && !type_b && lcd_tick && !disp_rst
		|=> pol_q != $past(pol_q))
		else $error("type A polarity did not invert");
	common_line_3_seg_a: assert property (state_q == ST_RUN && !duty4 |=> com_pin_level[3]
		== $past(seg_sig[23]))
		else $error("common pin 3 not segment 23 at third duty");
	idle_com_mid_a: assert property (state_q == ST_RUN && duty4 && share_q == 4'h0 && slot_q == 2'h0
		|=> com_pin_level[1] == LV_MID)
		else $error("inactive common not at mid bias");
endmodule // lsd_driver
`default_nettype wire

// File: shared/lsd_params.svh
// Register map, field positions, reset values and timing counts of the segment display driver
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH

// Register byte addresses
`define LSD_ADDR_CTRL 12'h000
`define LSD_ADDR_SHARE 12'h004
`define LSD_ADDR_STATUS 12'h008
`define LSD_ADDR_MEM_BASE 12'h040
`define LSD_ADDR_MEM_LAST 12'h0A0
`define LSD_MEM_WORDS 25

// Control register fields
`define LSD_CTRL_TYPE 7
`define LSD_CTRL_DUTY 5
`define LSD_CTRL_BIAS 4
`define LSD_CTRL_PUMP_HI 3
`define LSD_CTRL_PUMP_LO 1
`define LSD_CTRL_EN 0
`define LSD_CTRL_MASK 8'hBF
`define LSD_CTRL_RESET 8'h00

// Pin-share register fields
`define LSD_SHARE_PIN1_COM 3
`define LSD_SHARE_PIN0_COM 2
`define LSD_SHARE_COMMON_LINE_3_SEG 1
`define LSD_SHARE_COMMON_LINE_2_SEG 0
`define LSD_SHARE_RESET 4'h0

// Timing
`define LSD_CLK_HZ 250000000
`define LSD_CLK_PERIOD_NS 4
`define LSD_SLOW_OSC_HZ 32768
`define LSD_SLOW_OSC_CYCLES (`LSD_CLK_HZ / `LSD_SLOW_OSC_HZ)
`define LSD_DISPLAY_DIV 16'h0008
`define LSD_RESET_DELAY_NS 64
`define LSD_STARTUP_NS 1024
`define LSD_HOLD_CYCLES \
	((`LSD_RESET_DELAY_NS + `LSD_STARTUP_NS + `LSD_CLK_PERIOD_NS - 1) / `LSD_CLK_PERIOD_NS)

`endif

// File: shared/lsd_pkg.sv
// Types of the segment display driver
`default_nettype none
package lsd_pkg;

	// Driver state, Gray coded along float, off, run
	typedef enum logic [1:0] {
		ST_FLOAT = 2'h0,
		ST_OFF = 2'h1,
		ST_RUN = 2'h3
	} lsd_state_type;

	// Output pin level: ground, mid bias, pumped top
	typedef enum logic [1:0] {
		LV_LOW = 2'h0,
		LV_MID = 2'h1,
		LV_HIGH = 2'h2
	} lsd_level_type;

endpackage
`default_nettype wire

// File: src/lsd_tick_div.sv
// Programmable enable-pulse divider
`timescale 1ns/1ps
`default_nettype none
module lsd_tick_div (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic step_en,
	input wire logic [15:0] ratio,
	output logic tick
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;

	// Pulse on the last step of each ratio
	assign tick = step_en && !clear && (cnt_q >= ratio - 16'h0001);

	// Next count
	always_comb begin
		cnt_d = cnt_q;
		if (clear) begin
			cnt_d = 16'h0000;
		end else if (tick) begin
			cnt_d = 16'h0000;
		end else if (step_en) begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	// Count register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // lsd_tick_div
`default_nettype wire

// File: tb/lsd_panel_model.sv
// Glass panel model: pixel DC integral and segment flip count
`timescale 1ns/1ps
`default_nettype none
module lsd_panel_model (
	input wire logic pclk,
	input wire logic clear,
	input wire logic [3:0][1:0] com_pin_level,
	input wire logic [3:0] com_pin_oe,
	input wire logic [22:0][1:0] seg_pin_level,
	input wire logic [22:0] seg_pin_oe,
	output logic signed [31:0] dc_sum,
	output logic [31:0] seg_flips
);
	logic [1:0] last_seg;

	// Pixel on common 0 and segment 2; glass is passive, it only integrates
	always_ff @(posedge pclk) begin
		if (clear) begin
			dc_sum <= 32'sh0;
			seg_flips <= 32'h0;
		end else begin
			if (com_pin_oe[0] && seg_pin_oe[2])
				dc_sum <= dc_sum + $signed({30'h0, com_pin_level[0]})
					- $signed({30'h0, seg_pin_level[2]});
			if (seg_pin_level[2] != last_seg)
				seg_flips <= seg_flips + 32'h1; // Polarity change seen
		end
		last_seg <= seg_pin_level[2];
	end
endmodule // lsd_panel_model
`default_nettype wire

// File: tb/lsd_driver_bench.sv
// Self-checking bench of the segment display driver
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module lsd_driver_bench
	import lsd_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic sys_reset_req, wdt_lowpower_reset, bias_source_select, pump_clk_en, clear, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata, seg_flips;
	logic [3:0][1:0] com_pin_level;
	logic [3:0] com_pin_oe;
	logic [22:0][1:0] seg_pin_level;
	logic [22:0] seg_pin_oe;
	logic signed [31:0] dc_sum;
	logic [26:0] all_oe;
	logic [53:0] all_lv;
	int mismatches, samples_checked, fa, n, k;

	assign all_oe = {com_pin_oe, seg_pin_oe};
	assign all_lv = {com_pin_level, seg_pin_level};

	// Short slow-oscillator count keeps each display tick at 32 cycles
	lsd_driver #(.SLOW_OSC_CYCLES(16'h0004)) u_lsd_driver (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sys_reset_req,
		.wdt_lowpower_reset, .com_pin_level, .com_pin_oe, .seg_pin_level, .seg_pin_oe,
		.bias_source_select, .pump_clk_en);

	lsd_panel_model u_lsd_panel_model (.pclk, .clear, .com_pin_level, .com_pin_oe,
		.seg_pin_level, .seg_pin_oe, .dc_sum, .seg_flips);

	// Clock
	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end

	task finish_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task timeout();
		mismatches++;
		$display("CHECK FAILED wait exp done got timeout");
		finish_test();
	endtask

	// One APB transfer, answer taken at the pready edge, then one idle cycle
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'h1) break;
		end
		if (i == 20) timeout();
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	// Cycles up to the next pump pulse, bounded
	task wait_pump();
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pump_clk_en !== 1'h1 && n < 3000);
		if (n >= 3000) timeout();
	endtask

	// Settle, then watch 24 display ticks of pin pattern and pixel balance
	task watch(input logic [3:0] act, input logic [3:0] sgp, input logic shr);
		int bad, ext, j;
		logic [3:0] seen;
		bad = 0;
		seen = 4'h0;
		repeat (100) @(posedge pclk);
		clear <= 1'h1;
		@(posedge pclk);
		clear <= 1'h0;
		repeat (768) begin
			@(posedge pclk);
			ext = 0;
			for (j = 0; j < 4; j++) begin
				if (act[j] && com_pin_level[j] !== LV_MID) begin
					ext++;
					seen[j] = 1'h1;
				end
				if (sgp[j] && com_pin_level[j] === LV_MID) bad++;
			end
			if (ext > 1 || seg_pin_level[2] === LV_MID) bad++;
			if (shr && (seg_pin_level[0] !== com_pin_level[2]
				|| seg_pin_level[1] !== com_pin_level[3])) bad++;
		end
		@(posedge pclk);
		`CHK("pins", 0, bad)
		`CHK("slots", act, seen)
		`CHK("dc", 32'sh0, dc_sum)
	endtask

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, sys_reset_req, wdt_lowpower_reset, clear} = 7'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		mismatches = 0;
		samples_checked = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		repeat (260) @(posedge pclk);
		`CHK("float", 27'h0, all_oe)
		repeat (20) @(posedge pclk);
		`CHK("driven", 27'h7FFFFFF, all_oe)
		`CHK("low", 54'h0, all_lv)
		apb(1'h0, 12'h000, 32'h0);
		`CHK("ctrl reset", 32'h0, rdata)
		$display("test reset done");
		apb(1'h1, 12'h000, 32'hFFFFFFFE);
		apb(1'h0, 12'h000, 32'h0);
		`CHK("ctrl", 32'hBE, rdata)
		`CHK("bias", 1'h1, bias_source_select)
		apb(1'h1, 12'h004, 32'hF);
		apb(1'h0, 12'h004, 32'h0);
		`CHK("share quarter", 32'hC, rdata)
		apb(1'h1, 12'h000, 32'h0);
		apb(1'h0, 12'h004, 32'h0);
		`CHK("share third", 32'hF, rdata)
		`CHK("bias", 1'h0, bias_source_select)
		apb(1'h0, 12'h010, 32'h0);
		`CHK("unmapped", 33'h100000000, {rerr, rdata})
		$display("test registers done");
		for (k = 0; k < 8; k++) begin
			apb(1'h1, 12'h000, 32'(k * 2 + 1));
			wait_pump();
			wait_pump();
			wait_pump();
			`CHK("pump", (k == 7 ? 2 : 128 >> k) * 4, n)
		end
		$display("test pump done");
		apb(1'h1, 12'h004, 32'h0);
		apb(1'h1, 12'h048, 32'hF);
		apb(1'h1, 12'h09C, 32'h5);
		apb(1'h1, 12'h0A0, 32'hA);
		apb(1'h1, 12'h000, 32'h01);
		watch(4'h7, 4'h8, 1'h0);
		fa = seg_flips;
		apb(1'h1, 12'h000, 32'hA1);
		watch(4'hF, 4'h0, 1'h0);
		`CHK("type b slower", 1'h1, seg_flips * 2 < fa && fa >= 22)
		apb(1'h1, 12'h004, 32'hC);
		apb(1'h1, 12'h000, 32'h21);
		watch(4'hF, 4'h0, 1'h1);
		apb(1'h1, 12'h004, 32'h2);
		watch(4'h7, 4'h8, 1'h0);
		apb(1'h1, 12'h000, 32'h01);
		apb(1'h1, 12'h004, 32'h1);
		watch(4'h3, 4'hC, 1'h0);
		$display("test waveform done");
		apb(1'h1, 12'h000, 32'h0);
		repeat (5) @(posedge pclk);
		`CHK("off oe", 27'h7FFFFFF, all_oe)
		`CHK("off low", 54'h0, all_lv)
		apb(1'h1, 12'h000, 32'h01);
		sys_reset_req <= 1'h1;
		wdt_lowpower_reset <= 1'h1;
		repeat (3) @(posedge pclk);
		sys_reset_req <= 1'h0;
		wdt_lowpower_reset <= 1'h0;
		repeat (3) @(posedge pclk);
		`CHK("watchdog oe", 27'h7FFFFFF, all_oe)
		apb(1'h0, 12'h000, 32'h0);
		`CHK("watchdog ctrl", 32'h01, rdata)
		sys_reset_req <= 1'h1;
		@(posedge pclk);
		sys_reset_req <= 1'h0;
		repeat (3) @(posedge pclk);
		`CHK("sys float", 27'h0, all_oe)
		apb(1'h0, 12'h000, 32'h0);
		`CHK("sys ctrl", 32'h0, rdata)
		repeat (280) @(posedge pclk);
		`CHK("sys driven", 27'h7FFFFFF, all_oe)
		$display("test resets done");
		finish_test();
	end
endmodule // lsd_driver_bench
`default_nettype wire
